/* hdl/scan_status_flag_bank.sv */
// Scan status flag bank: read-only flags and data words of the scan engine.
// Assumes event inputs are one-cycle strobes synchronous to mclk.
// Function
// - Flags change only from internal conditions
// - Flags never drive external output terminals
// - Diagnostic error sets flag, stores code
// - I/O verify error sets flag, stores position
// - Sticky op error keeps first address
// - Pulse op error, latest address overwritten
// - Carry pulses on overflow, underflow, shift
// - Greater-than pulses on larger compare
// - Equal pulses on equal or zero result
// - Less-than pulses on smaller compare
// - Timer contact set at zero while triggered, cleared untriggered
// - Tool link error sets flag
// - Constant scan overrun sets flag
// - Toggle flag inverts every scan
`timescale 1ns/1ps
`include "scan_flag_cfg.svh"
module scan_status_flag_bank
	import scan_flag_pkg::*;
(
	// Clock and reset
	input wire logic mclk,
	input wire logic resetn,
	// Scan engine
	input wire logic scan_start,
	input wire logic const_scan_mode,
	input wire logic scan_time_over,
	// Error events
	input wire logic diag_err_evt,
	input wire word_t diag_err_code,
	input wire logic io_verify_evt,
	input wire word_t io_verify_pos,
	input wire logic op_err_evt,
	input wire word_t op_err_addr,
	input wire logic tool_link_err_evt,
	// Arithmetic and compare events
	input wire logic arith_carry_evt,
	input wire logic shift_carry_evt,
	input wire logic arith_zero_evt,
	input wire logic cmp_evt,
	input wire logic cmp_gt,
	input wire logic cmp_eq,
	input wire logic cmp_lt,
	// Auxiliary timer
	input wire logic aux_timer_zero,
	input wire logic aux_timer_trigger,
	// Internal flag read side only, never output terminals
	output logic diag_error_flag,
	output word_t diag_error_code_word,
	output logic io_verify_error_flag,
	output word_t io_verify_position_word,
	output logic op_error_sticky_flag,
	output word_t first_op_error_addr_word,
	output logic op_error_pulse_flag,
	output word_t latest_op_error_addr_word,
	output logic carry_flag_bit,
	output logic greater_than_flag,
	output logic equal_flag,
	output logic less_than_flag,
	output logic aux_timer_contact,
	output logic tool_link_error_flag,
	output logic scan_overrun_flag,
	output logic constant_one_flag,
	output logic constant_zero_flag,
	output logic scan_toggle_flag
);
	// ***************************************************
	// Pulse flags
	// ***************************************************
	logic [4:0] pset; // Pulse set events
	logic [4:0] pflag; // Pulse flag states
	assign pset[0] = op_err_evt;
	assign pset[1] = arith_carry_evt | shift_carry_evt;
	assign pset[2] = cmp_evt & cmp_gt;
	assign pset[3] = (cmp_evt & cmp_eq) | arith_zero_evt;
	assign pset[4] = cmp_evt & cmp_lt;
	genvar gi;
	generate
		for (gi = 0; gi < 5; gi++) begin : g_pulse
			pulse_flag u_pf (
				.mclk(mclk),
				.resetn(resetn),
				.scan_start(scan_start),
				.set_evt(pset[gi]),
				.flag(pflag[gi])
			);
		end
	endgenerate
	assign op_error_pulse_flag = pflag[0];
	assign carry_flag_bit = pflag[1];
	assign greater_than_flag = pflag[2];
	assign equal_flag = pflag[3];
	assign less_than_flag = pflag[4];
	// ***************************************************
	// Constant flags
	// ***************************************************
	// No write port exists; only internal events reach the flags
	assign constant_one_flag = `CONST_ONE;
	assign constant_zero_flag = `CONST_ZERO;
	// ***************************************************
	// Error flags and words
	// ***************************************************
	// Diagnostic error and code
	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			diag_error_flag <= `FLAG_RST;
			diag_error_code_word <= `WORD_RST;
		end else if (diag_err_evt) begin
			diag_error_flag <= 1'b1;
			diag_error_code_word <= diag_err_code;
		end
	end
	// I/O verify error and position
	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			io_verify_error_flag <= `FLAG_RST;
			io_verify_position_word <= `WORD_RST;
		end else if (io_verify_evt) begin
			io_verify_error_flag <= 1'b1;
			io_verify_position_word <= io_verify_pos;
		end
	end
	// Sticky op error keeps the first address
	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			op_error_sticky_flag <= `FLAG_RST;
			first_op_error_addr_word <= `WORD_RST;
		end else if (op_err_evt && !op_error_sticky_flag) begin
			op_error_sticky_flag <= 1'b1;
			first_op_error_addr_word <= op_err_addr;
		end
	end
	// Latest op error address
	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			latest_op_error_addr_word <= `WORD_RST;
		end else if (op_err_evt) begin
			latest_op_error_addr_word <= op_err_addr;
		end
	end
	// Tool link error
	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			tool_link_error_flag <= `FLAG_RST;
		end else if (tool_link_err_evt) begin
			tool_link_error_flag <= 1'b1;
		end
	end
	// Constant scan overrun
	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			scan_overrun_flag <= `FLAG_RST;
		end else if (const_scan_mode && scan_time_over) begin
			scan_overrun_flag <= 1'b1;
		end
	end
	// ***************************************************
	// Timer contact and scan toggle
	// ***************************************************
	// Trigger release wins over zero count
	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			aux_timer_contact <= `FLAG_RST;
		end else if (aux_timer_zero && aux_timer_trigger) begin
			aux_timer_contact <= 1'b1;
		end else if (!aux_timer_trigger) begin
			aux_timer_contact <= 1'b0;
		end
	end
	// Toggle at every scan start
	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			scan_toggle_flag <= `FLAG_RST;
		end else if (scan_start) begin
			scan_toggle_flag <= ~scan_toggle_flag;
		end
	end
	// ***************************************************
	// Assertions
	// ***************************************************
	sequence s_op_err;
		op_err_evt && !op_error_sticky_flag;
	endsequence
	property p_first_addr;
		@(posedge mclk) disable iff (!resetn)
		s_op_err |=> op_error_sticky_flag && first_op_error_addr_word == $past(op_err_addr);
	endproperty
	a_first_addr: assert property (p_first_addr) else $error("first addr wrong");
	property p_first_hold;
		@(posedge mclk) disable iff (!resetn)
		op_error_sticky_flag |=> $stable(first_op_error_addr_word) && op_error_sticky_flag;
	endproperty
	a_first_hold: assert property (p_first_hold) else $error("first addr moved");
	property p_latest;
		@(posedge mclk) disable iff (!resetn)
		op_err_evt |=> latest_op_error_addr_word == $past(op_err_addr) && op_error_pulse_flag;
	endproperty
	a_latest: assert property (p_latest) else $error("latest addr wrong");
	property p_diag;
		@(posedge mclk) disable iff (!resetn)
		diag_err_evt |=> diag_error_flag && diag_error_code_word == $past(diag_err_code);
	endproperty
	a_diag: assert property (p_diag) else $error("diag not stored");
	property p_iov;
		@(posedge mclk) disable iff (!resetn)
		io_verify_evt |=> io_verify_error_flag && io_verify_position_word == $past(io_verify_pos);
	endproperty
	a_iov: assert property (p_iov) else $error("io verify not stored");
	property p_pulse_clr;
		@(posedge mclk) disable iff (!resetn)
		scan_start && !pset[2] |=> !greater_than_flag;
	endproperty
	a_pulse_clr: assert property (p_pulse_clr) else $error("pulse not cleared");
	property p_eq;
		@(posedge mclk) disable iff (!resetn)
		arith_zero_evt |=> equal_flag;
	endproperty
	a_eq: assert property (p_eq) else $error("equal not set");
	property p_toggle;
		@(posedge mclk) disable iff (!resetn)
		scan_start |=> scan_toggle_flag != $past(scan_toggle_flag);
	endproperty
	a_toggle: assert property (p_toggle) else $error("toggle missed");
	property p_timer;
		@(posedge mclk) disable iff (!resetn)
		!aux_timer_trigger |=> !aux_timer_contact;
	endproperty
	a_timer: assert property (p_timer) else $error("contact not cleared");
	property p_overrun;
		@(posedge mclk) disable iff (!resetn)
		const_scan_mode && scan_time_over |=> scan_overrun_flag;
	endproperty
	a_overrun: assert property (p_overrun) else $error("overrun missed");
	property p_const;
		@(posedge mclk) constant_one_flag && !constant_zero_flag;
	endproperty
	a_const: assert property (p_const) else $error("constant flags wrong");
	// Without their events the diag, I/O verify and tool link flags and words never move
	property p_no_write;
		@(posedge mclk) disable iff (!resetn)
		!diag_err_evt && !io_verify_evt && !tool_link_err_evt |=>
			$stable(diag_error_flag) && $stable(diag_error_code_word) &&
			$stable(io_verify_error_flag) && $stable(io_verify_position_word) &&
			$stable(tool_link_error_flag);
	endproperty
	a_no_write: assert property (p_no_write) else $error("flag moved without event");
endmodule

/* hdl/scan_flag_cfg.svh */
// Constants for the scan status flag bank: reset values and widths.
// Assumes inclusion by bare name; definitions only.
`ifndef SCAN_FLAG_CFG_SVH
`define SCAN_FLAG_CFG_SVH
`define WORD_W 16
`define WORD_RST 16'h0000
`define FLAG_RST 1'b0
`define CONST_ONE 1'b1
`define CONST_ZERO 1'b0
`endif

/* hdl/scan_flag_pkg.sv */
// Types for the scan status flag bank.
// Assumes the cfg header is reachable on the include path.
`include "scan_flag_cfg.svh"
package scan_flag_pkg;
	typedef logic [`WORD_W-1:0] word_t;
	// Per-scan phase of the flag bank
	typedef enum logic [1:0] {
		ph_idle_t = 2'b00,
		ph_run_t = 2'b01
	} phase_t;
endpackage

/* hdl/pulse_flag.sv */
// One-scan pulse flag: set by an event, cleared at the next scan start.
// Assumes scan_start and event are synchronous to mclk.
`timescale 1ns/1ps
module pulse_flag (
	// Clock and reset
	input wire logic mclk,
	input wire logic resetn,
	// Controls
	input wire logic scan_start,
	input wire logic set_evt,
	// Flag
	output logic flag
);
	// Event wins over the scan-start clear
	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			flag <= 1'b0;
		end else if (set_evt) begin
			flag <= 1'b1;
		end else if (scan_start) begin
			flag <= 1'b0;
		end
	end
endmodule

/* tb/scan_status_flag_bank_tb.sv */
// Self-checking testbench for the scan status flag bank.
// Assumes scan_flag_pkg is compiled first; the bench drives every input itself.
`timescale 1ns/1ps
module scan_status_flag_bank_tb
	import scan_flag_pkg::*;
;
	// ********************************
	// Signals
	// ********************************
	logic mclk, resetn, const_scan_mode, cmp_gt, cmp_eq, cmp_lt;
	logic aux_timer_zero, aux_timer_trigger;
	logic [9:0] ev; // Event strobes, one bit per event input
	word_t dat; // Data shared by the three data inputs
	logic diag_error_flag, io_verify_error_flag, op_error_sticky_flag, op_error_pulse_flag;
	logic carry_flag_bit, greater_than_flag, equal_flag, less_than_flag, aux_timer_contact;
	logic tool_link_error_flag, scan_overrun_flag, constant_one_flag, constant_zero_flag;
	logic scan_toggle_flag;
	word_t diag_error_code_word, io_verify_position_word;
	word_t first_op_error_addr_word, latest_op_error_addr_word;
	int mismatches = 0;
	int tests_run = 0;

	// Device under test, events taken from the strobe vector
	scan_status_flag_bank uut (.mclk, .resetn, .scan_start(ev[8]), .const_scan_mode,
		.scan_time_over(ev[9]), .diag_err_evt(ev[0]), .diag_err_code(dat),
		.io_verify_evt(ev[1]), .io_verify_pos(dat), .op_err_evt(ev[2]), .op_err_addr(dat),
		.tool_link_err_evt(ev[3]), .arith_carry_evt(ev[4]), .shift_carry_evt(ev[5]),
		.arith_zero_evt(ev[6]), .cmp_evt(ev[7]), .cmp_gt, .cmp_eq, .cmp_lt, .aux_timer_zero,
		.aux_timer_trigger, .diag_error_flag, .diag_error_code_word, .io_verify_error_flag,
		.io_verify_position_word, .op_error_sticky_flag, .first_op_error_addr_word,
		.op_error_pulse_flag, .latest_op_error_addr_word, .carry_flag_bit, .greater_than_flag,
		.equal_flag, .less_than_flag, .aux_timer_contact, .tool_link_error_flag,
		.scan_overrun_flag, .constant_one_flag, .constant_zero_flag, .scan_toggle_flag);

	// ********************************
	// Clock, reset and watchdog
	// ********************************
	initial begin
		mclk = 1'b0;
		forever #20 mclk = ~mclk;
	end

	// Cuts a hang far beyond the hundred or so cycles the run needs
	initial begin
		repeat (3000) @(posedge mclk);
		mismatches++;
		close_out();
	end

	// ********************************
	// Helpers
	// ********************************
	task close_out;
		$display("mismatches=%0d tests_run=%0d", mismatches, tests_run);
		if (mismatches == 0 && tests_run > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask

	// Single flag compare
	task chk1(input logic got, input logic exp);
		tests_run++;
		if (got !== exp) begin
			mismatches++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	// Data word compare
	task chkw(input word_t got, input word_t exp);
		tests_run++;
		if (got !== exp) begin
			mismatches++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	// One-cycle strobe with data, then settle past the taking edge
	task fire(input logic [9:0] m, input word_t d);
		@(posedge mclk);
		ev <= m;
		dat <= d;
		@(posedge mclk);
		ev <= 10'h000;
		#1;
	endtask

	// Start of a new scan
	task scan;
		fire(10'h100, 16'h0000);
	endtask

	// ********************************
	// Scenarios
	// ********************************
	task t_reset;
		chk1(diag_error_flag, 1'b0);
		chk1(op_error_sticky_flag, 1'b0);
		chkw(first_op_error_addr_word, 16'h0000);
		chk1(constant_one_flag, 1'b1);
		chk1(constant_zero_flag, 1'b0);
	endtask

	task t_errors;
		fire(10'h00b, 16'h1234);
		chk1(diag_error_flag, 1'b1);
		chkw(diag_error_code_word, 16'h1234);
		chk1(io_verify_error_flag, 1'b1);
		chkw(io_verify_position_word, 16'h1234);
		chk1(tool_link_error_flag, 1'b1);
		fire(10'h001, 16'h00ff);
		scan();
		chkw(diag_error_code_word, 16'h00ff);
		chkw(io_verify_position_word, 16'h1234);
		chk1(diag_error_flag, 1'b1);
	endtask

	task t_op;
		fire(10'h004, 16'h0100);
		chk1(op_error_pulse_flag, 1'b1);
		fire(10'h004, 16'h0200);
		chkw(first_op_error_addr_word, 16'h0100);
		chkw(latest_op_error_addr_word, 16'h0200);
		scan();
		chk1(op_error_pulse_flag, 1'b0);
		chk1(op_error_sticky_flag, 1'b1);
		fire(10'h104, 16'h0300);
		chk1(op_error_pulse_flag, 1'b1);
		chkw(first_op_error_addr_word, 16'h0100);
		scan();
		chk1(op_error_pulse_flag, 1'b0);
	endtask

	task t_arith;
		fire(10'h010, 16'h0000);
		chk1(carry_flag_bit, 1'b1);
		scan();
		chk1(carry_flag_bit, 1'b0);
		fire(10'h060, 16'h0000);
		chk1(carry_flag_bit, 1'b1);
		chk1(equal_flag, 1'b1);
		scan();
		chk1(equal_flag, 1'b0);
		for (int i = 0; i < 3; i++) begin
			@(posedge mclk);
			{cmp_gt, cmp_eq, cmp_lt} <= 3'h4 >> i;
			fire(10'h080, 16'h0000);
			chk1(greater_than_flag, i == 0);
			chk1(equal_flag, i == 1);
			chk1(less_than_flag, i == 2);
			scan();
			chk1(greater_than_flag | equal_flag | less_than_flag, 1'b0);
		end
	endtask

	task t_timer;
		@(posedge mclk);
		aux_timer_zero <= 1'b1;
		@(posedge mclk);
		aux_timer_zero <= 1'b0;
		#1 chk1(aux_timer_contact, 1'b0);
		@(posedge mclk);
		aux_timer_trigger <= 1'b1;
		@(posedge mclk);
		#1 chk1(aux_timer_contact, 1'b0);
		@(posedge mclk);
		aux_timer_zero <= 1'b1;
		@(posedge mclk);
		aux_timer_zero <= 1'b0;
		repeat (3) @(posedge mclk);
		#1 chk1(aux_timer_contact, 1'b1);
		@(posedge mclk);
		aux_timer_trigger <= 1'b0;
		@(posedge mclk);
		#1 chk1(aux_timer_contact, 1'b0);
	endtask

	task t_overrun;
		fire(10'h200, 16'h0000);
		chk1(scan_overrun_flag, 1'b0);
		@(posedge mclk);
		const_scan_mode <= 1'b1;
		fire(10'h200, 16'h0000);
		scan();
		chk1(scan_overrun_flag, 1'b1);
	endtask

	task t_toggle;
		logic t;
		t = scan_toggle_flag;
		scan();
		chk1(scan_toggle_flag, ~t);
		repeat (4) @(posedge mclk);
		scan();
		chk1(scan_toggle_flag, t);
	endtask

	// ********************************
	// Main sequence
	// ********************************
	initial begin
		resetn = 1'b0;
		ev = 10'h000;
		dat = 16'h0000;
		{const_scan_mode, cmp_gt, cmp_eq, cmp_lt, aux_timer_zero, aux_timer_trigger} = 6'h00;
		repeat (16) @(posedge mclk);
		resetn <= 1'b1;
		#1 t_reset();
		t_errors();
		t_op();
		t_arith();
		t_timer();
		t_overrun();
		t_toggle();
		@(posedge mclk);
		resetn <= 1'b0;
		#1 chk1(op_error_sticky_flag, 1'b0);
		close_out();
	end
endmodule
